// ### shared/asq_pkg.sv
// Purpose: Constants and carrier types for the sleep-state power sequencer
// Assumes: 40 MHz system clock, all inputs synchronous to it
// Notes: Times are kept in their own units; cycle counts derive from them
package asq_pkg;

  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 40000;

  // Request filter interval in ns, rounded up to cycles
  localparam int unsigned FILT_NS = 2000;
  localparam int unsigned FILT_CYC = (FILT_NS * CLK_KHZ + 999_999) / 1_000_000;

  // Active-to-sleep delay in us
  localparam int unsigned SLP_DLY_US = 200;
  localparam int unsigned SLP_DLY_CYC = (SLP_DLY_US * CLK_KHZ) / 1000;

  // Main-rail qualification wait in ms, nominal figure
  localparam int unsigned QUAL_MS = 25;
  localparam int unsigned QUAL_CYC = QUAL_MS * CLK_KHZ;

  // Power-good delay default in us, stands for the timing capacitor
  localparam int unsigned PG_DLY_US = 1000;
  localparam int unsigned PG_DLY_CYC = PG_DLY_US * (CLK_KHZ / 1000);

  // Counter widths
  localparam int unsigned CNT_W = 20;
  localparam int unsigned FILT_W = 7;

  // Filtered request reset levels (inactive = high)
  localparam logic REQ_RST = 1'b1;

  // Operating states
  typedef enum logic [1:0]
  {
    ST_QUAL = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SUSPEND = 2'b10,
    ST_SOFTOFF = 2'b11
  } asq_state_t;

  // Monitor inputs from the analog comparators
  typedef struct packed
  {
    logic main_three_uv;
    logic dual_three_uv;
    logic dual_five_uv;
    logic standby_reg_uv;
    logic vid_reg_uv;
    logic temp_fault;
    logic temp_shutdown;
  } asq_mon_t;

  // Rail enable outputs
  typedef struct packed
  {
    logic standby_regulator_out;
    logic vid_regulator_out;
    logic dual_five_standby_switch;
    logic dual_three_standby_drive;
    logic main_rail_gate_drive;
  } asq_rail_t;

endpackage : asq_pkg

// ### design/asq_sequencer.sv
// Purpose: Sleep-state control and supervision of a multi-rail power controller
// Assumes: Requests and monitors are synchronous to sys_clk; nrst is power-on reset
// Notes: Analog regulation and thresholds live outside; only digital decisions here
module asq_sequencer
  import asq_pkg::*;
#(
  parameter bit VARIANT_SOFTOFF_DUAL5 = 1'b0,
  parameter int unsigned QUAL_CYCLES = QUAL_CYC,
  parameter int unsigned PG_CYCLES = PG_DLY_CYC
)
(
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Chipset sleep requests
  input wire logic suspend_ram_req_n,
  input wire logic soft_off_req_n,
  // Soft-start pin, two-way: input level plus open-drain pull-down
  input wire logic ss_pin_in,
  output logic ss_pin_out,
  output logic ss_pin_oe_n,
  // Analog monitor results
  input wire asq_mon_t mon,
  // Rail controls
  output asq_rail_t rails,
  // Status outputs
  output logic vid_power_good,
  output logic fault,
  output asq_state_t state_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Filtered request levels
  logic filt_s3_n;
  logic filt_s5_n;
  // Filter counters, one per request
  logic [FILT_W-1:0] filt_cnt [2];
  // Sleep-entry delay timer and its running flag
  logic [CNT_W-1:0] slp_cnt;
  logic slp_run;
  // Qualification wait counter
  logic [CNT_W-1:0] qual_cnt;
  // Power-good delay counter
  logic [CNT_W-1:0] pg_cnt;
  // Present state and its next value
  asq_state_t state;
  asq_state_t next_state;
  // Shutdown request from pin or die temperature
  logic shut;
  // Raw and filtered request vectors
  logic [1:0] raw_req;
  logic [1:0] filt_req;

  assign raw_req = {soft_off_req_n, suspend_ram_req_n};
  assign filt_s3_n = filt_req[0];
  assign filt_s5_n = filt_req[1];
  assign shut = ~ss_pin_in | mon.temp_shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // Request deglitch filters

  // A new level is taken only after it holds for the full interval
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_filt
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          filt_req[i] <= REQ_RST;
          filt_cnt[i] <= '0;
        end
        else if (raw_req[i] == filt_req[i])
        begin
          // Level agrees: restart the count
          filt_cnt[i] <= '0;
        end
        else if (filt_cnt[i] == FILT_W'(FILT_CYC - 1))
        begin
          // Held long enough: accept the new level
          filt_req[i] <= raw_req[i];
          filt_cnt[i] <= '0;
        end
        else
        begin
          // Still counting a possible glitch
          filt_cnt[i] <= filt_cnt[i] + 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sleep-entry delay timer

  // Starts when the filtered suspend request falls in the active state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slp_run <= 1'b0;
      slp_cnt <= '0;
    end
    else if (state != ST_ACTIVE || filt_s3_n)
    begin
      // Not in active or request withdrawn: abandon the delay
      slp_run <= 1'b0;
      slp_cnt <= '0;
    end
    else if (!slp_run)
    begin
      // Request just seen low: arm the timer
      slp_run <= 1'b1;
      slp_cnt <= '0;
    end
    else if (slp_cnt != CNT_W'(SLP_DLY_CYC - 1))
    begin
      // Counting the delay
      slp_cnt <= slp_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main-rail qualification wait

  // Counts while in the wait state and the main input is good
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      qual_cnt <= '0;
    end
    else if (state != ST_QUAL || mon.main_three_uv)
    begin
      // Rail dropped or not waiting: start over
      qual_cnt <= '0;
    end
    else if (qual_cnt != CNT_W'(QUAL_CYCLES - 1))
    begin
      // Accumulating good time
      qual_cnt <= qual_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State decision

  // Legal moves only: wait or active to a sleep state and back through the wait
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_QUAL:
      begin
        // A low suspend request leaves the wait at once (soft-off if both low); active only when the main rail has been good long enough
        if (!filt_s3_n && filt_s5_n)
          next_state = ST_SUSPEND;
        else if (!filt_s3_n && !filt_s5_n)
          next_state = ST_SOFTOFF;
        else if (!mon.main_three_uv && qual_cnt == CNT_W'(QUAL_CYCLES - 1))
          next_state = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        // Delay done: soft-off if that request is low, else suspend
        if (slp_run && slp_cnt == CNT_W'(SLP_DLY_CYC - 1))
          next_state = filt_s5_n ? ST_SUSPEND : ST_SOFTOFF;
      end
      ST_SUSPEND:
      begin
        // Wake only on both high; soft-off low with suspend high holds
        if (filt_s3_n && filt_s5_n)
          next_state = ST_QUAL;
        // Low-low from suspend would be a direct move: refused
      end
      ST_SOFTOFF:
      begin
        // Wake only on both high; suspend request alone is refused
        if (filt_s3_n && filt_s5_n)
          next_state = ST_QUAL;
      end
    endcase
  end

  // State register; power-up enters the wait, which also sees the requests
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state <= ST_QUAL;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail controls

  // Per-state output choice, all forced off while shut down
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rails <= '0;
    end
    else if (shut)
    begin
      // Pin held low or die too hot: every output off
      rails <= '0;
    end
    else
    begin
      rails.standby_regulator_out <= 1'b1;
      rails.vid_regulator_out <= (state == ST_ACTIVE);
      rails.main_rail_gate_drive <= (state == ST_ACTIVE);
      rails.dual_three_standby_drive <= (state != ST_ACTIVE);
      rails.dual_five_standby_switch <= (state == ST_SUSPEND) ||
        (VARIANT_SOFTOFF_DUAL5 && state == ST_SOFTOFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // VID power-good with delay

  // Counter restarts whenever the VID output is off or undervoltage
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pg_cnt <= '0;
      vid_power_good <= 1'b0;
    end
    else if (mon.vid_reg_uv || !rails.vid_regulator_out)
    begin
      // Output below threshold: hold power-good low
      pg_cnt <= '0;
      vid_power_good <= 1'b0;
    end
    else if (pg_cnt != CNT_W'(PG_CYCLES - 1))
    begin
      // Good but delay not yet run out
      pg_cnt <= pg_cnt + 1'b1;
    end
    else
    begin
      vid_power_good <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault and status outputs

  // Fault reports undervoltage on any rail (VID only while its output is on) or overtemperature, masked by pin
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fault <= 1'b0;
    else if (!ss_pin_in)
      fault <= 1'b0;
    else
      fault <= mon.main_three_uv | mon.dual_three_uv | mon.dual_five_uv |
        mon.standby_reg_uv | (mon.vid_reg_uv & rails.vid_regulator_out) |
        mon.temp_fault | mon.temp_shutdown;
  end

  // Soft-start pin is never pulled by this block; state is visible
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ss_pin_out <= 1'b0;
      ss_pin_oe_n <= 1'b1;
      state_out <= ST_QUAL;
    end
    else
    begin
      ss_pin_out <= 1'b0;
      ss_pin_oe_n <= 1'b1;
      state_out <= state;
    end
  end

endmodule : asq_sequencer

// ### sim/asq_checker.sv
// Purpose: Port assertions for the sleep-state sequencer
// Assumes: One clock domain, nrst asynchronous and active low
// Notes: Bound to every sequencer instance at the foot of this file
module asq_checker
  import asq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Soft-start pin level
  input wire logic ss_pin_in,
  // Monitors and outputs
  input wire asq_mon_t mon,
  input wire asq_rail_t rails,
  input wire logic vid_power_good,
  input wire logic fault,
  input wire asq_state_t state_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  // Any fault source but VID undervoltage, seen with the soft-start pin high on two edges
  sequence src_seen;
    (|{mon[6:3], mon[1:0]} && ss_pin_in) ##1 ss_pin_in;
  endsequence
  // Entry into the active state from the wait state
  sequence qual_done;
    $past(state_out) == ST_QUAL && state_out == ST_ACTIVE;
  endsequence
  ////////////////////////////////////////////////////////////////////
  chk_fault_raise: assert property (src_seen |-> fault)
    else $error("fault not raised");
  chk_ss_shutdown: assert property (!ss_pin_in |=> rails == '0 && !fault)
    else $error("soft-start low did not shut down");
  chk_temp_off: assert property (mon.temp_shutdown |=> rails == '0)
    else $error("overtemperature left rails on");
  chk_vid_active: assert property (rails.vid_regulator_out |-> state_out == ST_ACTIVE)
    else $error("vid rail on outside active");
  chk_gate_active: assert property (rails.main_rail_gate_drive |-> state_out == ST_ACTIVE)
    else $error("gate drive released outside active");
  chk_standby_on: assert property ((ss_pin_in && !mon.temp_shutdown) [*2]
    |-> rails.standby_regulator_out)
    else $error("standby regulator off");
  chk_no_swap: assert property (state_out[1] |=> !state_out[1] || $stable(state_out))
    else $error("direct sleep to sleep move");
  chk_pg_uv: assert property (mon.vid_reg_uv |=> !vid_power_good)
    else $error("power good high during undervoltage");
  chk_pg_delay: assert property ($rose(vid_power_good)
    |-> $past(rails.vid_regulator_out, 8) && $past(mon.vid_reg_uv) == 1'b0)
    else $error("power good rose too early");
  chk_qual_clean: assert property (qual_done |-> $past(mon.main_three_uv, 3) == 1'b0)
    else $error("active entered with main rail low");
endmodule : asq_checker

bind asq_sequencer asq_checker u_chk (.sys_clk, .nrst, .ss_pin_in, .mon, .rails,
  .vid_power_good, .fault, .state_out);

// ### sim/asq_chipset.sv
// Purpose: Chipset side driving the two sleep requests
// Assumes: Bench commands levels {soft-off, suspend}, low = request
// Notes: Levels change only at the falling clock edge
module asq_chipset
(
  // Clock and command
  input wire logic sys_clk,
  input wire logic [1:0] cmd,
  // Request pins
  output logic suspend_ram_req_n,
  output logic soft_off_req_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-ups keep both lines inactive until the first command
  initial {soft_off_req_n, suspend_ram_req_n} = 2'h3;
  // Copy the commanded levels onto the request pins at each falling edge
  always @(negedge sys_clk)
  begin
    {soft_off_req_n, suspend_ram_req_n} <= cmd;
  end
endmodule : asq_chipset

// ### sim/asq_sequencer_tb.sv
// Purpose: Self-checking bench for the sleep-state sequencer
// Assumes: Short wait and power-good counts set by parameter
// Notes: Inputs change on the falling edge
module asq_sequencer_tb
  import asq_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, nrst, ss_pin_in, ss_pin_out, ss_pin_oe_n, vid_power_good, fault;
  logic suspend_ram_req_n, soft_off_req_n;
  logic [1:0] cmd;
  asq_mon_t mon;
  asq_rail_t rails;
  asq_state_t state_out;
  // Outputs of the variant instance that keeps the dual five switch on in soft-off
  asq_rail_t rails_a;
  asq_state_t state_a;
  logic pg_a, fault_a, ss_out_a, ss_oe_a_n;
  int bad_count, n_tests, cycles;

  asq_chipset u_chip (.sys_clk, .cmd, .suspend_ram_req_n, .soft_off_req_n);
  asq_sequencer #(.QUAL_CYCLES(50), .PG_CYCLES(20)) DUT (.sys_clk, .nrst,
    .suspend_ram_req_n, .soft_off_req_n, .ss_pin_in, .ss_pin_out, .ss_pin_oe_n,
    .mon, .rails, .vid_power_good, .fault, .state_out);
  asq_sequencer #(.VARIANT_SOFTOFF_DUAL5(1'b1), .QUAL_CYCLES(50), .PG_CYCLES(20)) DUT_A (
    .sys_clk, .nrst, .suspend_ram_req_n, .soft_off_req_n, .ss_pin_in,
    .ss_pin_out(ss_out_a), .ss_pin_oe_n(ss_oe_a_n), .mon, .rails(rails_a),
    .vid_power_good(pg_a), .fault(fault_a), .state_out(state_a));

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Wait for a state under a bound, then compare
  task automatic go(input logic [1:0] c, input asq_state_t exp, input int lim);
    cmd <= c;
    for (int i = 0; i < lim && state_out !== exp; i++)
      @(negedge sys_clk);
    check("state", exp, state_out);
  endtask : go
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, ss_pin_in, cmd, mon} = {1'b0, 1'b1, 2'h3, 7'h00};
    {bad_count, n_tests, cycles} = '0;
    cyc(5);
    nrst <= 1'b1;
    cyc(2);
    check("standby", 5'h01, rails.standby_regulator_out);
    cyc(40);
    check("early", ST_QUAL, state_out);
    go(2'h3, ST_ACTIVE, 40);
    check("rails", 5'h19, rails);
    cyc(10);
    check("pg early", 5'h00, vid_power_good);
    cyc(15);
    check("pg", 5'h01, vid_power_good);
    mon.vid_reg_uv <= 1'b1;
    cyc(2);
    check("pg uv", 5'h00, vid_power_good);
    check("fault vid", 5'h01, fault);
    mon.vid_reg_uv <= 1'b0;
    cmd <= 2'h2;
    cyc(70);
    cmd <= 2'h3;
    cyc(8200);
    check("glitch", ST_ACTIVE, state_out);
    cmd <= 2'h2;
    cyc(7950);
    check("delay", ST_ACTIVE, state_out);
    go(2'h2, ST_SUSPEND, 300);
    check("rails", 5'h16, rails);
    cmd <= 2'h1;
    cyc(300);
    check("illegal", ST_SUSPEND, state_out);
    cmd <= 2'h0;
    cyc(8300);
    check("swap", ST_SUSPEND, state_out);
    go(2'h3, ST_QUAL, 300);
    go(2'h3, ST_ACTIVE, 300);
    go(2'h0, ST_SOFTOFF, 8400);
    check("rails", 5'h12, rails);
    check("variant rails", 5'h16, rails_a);
    go(2'h3, ST_ACTIVE, 400);
    for (int i = 0; i < 7; i++)
      if (i != 2)
      begin
        mon <= asq_mon_t'(7'h01 << i);
        cyc(2);
        check("fault", 5'h01, fault);
        if (i == 0)
          check("hot rails", 5'h00, rails);
      end
    mon <= 7'h02;
    ss_pin_in <= 1'b0;
    cyc(2);
    check("ss rails", 5'h00, rails);
    check("ss fault", 5'h00, fault);
    check("ss pin oe", 5'h01, ss_pin_oe_n);
    check("ss pin out", 5'h00, ss_pin_out);
    conclude();
  end
endmodule : asq_sequencer_tb
